/* File: aite_defines.svh */
// Offsets, field positions, reset values and timing counts of the engine
`ifndef AITE_DEFINES_SVH
`define AITE_DEFINES_SVH
`define AITE_ENGINES      8
`define AITE_SEL_W        3
`define AITE_ADDR_W       8
`define AITE_DATA_W       32
`define AITE_CLK_MHZ      250
`define AITE_PAD_NS       10000
`define AITE_PAD_CYC      ((`AITE_PAD_NS * `AITE_CLK_MHZ) / 1000)
// Per-engine register offsets, engine index in address bits 7:5
`define AITE_OFS_CTRL     5'h00
`define AITE_OFS_DIV      5'h04
`define AITE_OFS_DELAY    5'h08
`define AITE_OFS_BUFSZ    5'h0C
`define AITE_OFS_PRETRIG  5'h10
`define AITE_OFS_CONV     5'h14
`define AITE_OFS_STATUS   5'h18
`define AITE_OFS_COUNT    5'h1C
// Control field positions
`define AITE_C_RUN        0
`define AITE_C_STOP       1
`define AITE_C_CONT       2
`define AITE_C_HARDWARE_TIMED_SINGLE_POINT      3
`define AITE_C_EXTCLK     4
`define AITE_C_REFEN      5
`define AITE_C_STSRC_L    6
`define AITE_C_STSRC_H    8
`define AITE_C_STFALL     9
`define AITE_C_RFSRC_L    10
`define AITE_C_RFSRC_H    12
`define AITE_C_RFFALL     13
`define AITE_C_PSEN       14
`define AITE_C_PSSRC_L    15
`define AITE_C_PSSRC_H    17
`define AITE_C_PSLOW      18
`define AITE_C_MODS_L     19
`define AITE_C_MODS_H     26
`define AITE_C_NCH_L      27
`define AITE_C_NCH_H      30
`define AITE_C_TIMING     31
`define AITE_CTRL_RST     32'h00000000
`define AITE_DIV_RST      32'h00000064
`endif

/* File: aite_engine.sv */
// Eight analog input timing engines with triggers and convert bursts
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "aite_defines.svh"
module aite_engine #(
  parameter int ENG   = `AITE_ENGINES,
  parameter int NSRC  = 8,
  parameter int NMOD  = 8
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [`AITE_ADDR_W-1:0] addr_i,
  input  wire logic [`AITE_DATA_W-1:0] wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [`AITE_DATA_W-1:0] rdata_o,
  input  wire logic [NSRC-1:0]         trig_src_i,
  input  wire logic [ENG-1:0]          ext_strobe_i,
  input  wire logic [ENG-1:0]          sample_read_i,
  output aite_pkg::aite_route_t        route_o,
  output aite_pkg::aite_conv_t         conv_o,
  output logic [ENG-1:0]               store_o,
  output logic [ENG-1:0]               drop_oldest_o,
  output logic [ENG-1:0]               late_warn_o,
  output logic [NMOD-1:0]              mod_conflict_o
);
  // Two-flop synchronisers on pins
  logic [NSRC-1:0] src_m_r, src_s_r, src_d_r;
  logic [ENG-1:0]  ext_m_r, ext_s_r, ext_d_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_m_r <= '0;
      src_s_r <= '0;
      src_d_r <= '0;
      ext_m_r <= '0;
      ext_s_r <= '0;
      ext_d_r <= '0;
    end else begin
      src_m_r <= trig_src_i;
      src_s_r <= src_m_r;
      src_d_r <= src_s_r;
      ext_m_r <= ext_strobe_i;
      ext_s_r <= ext_m_r;
      ext_d_r <= ext_s_r;
    end
  end

  logic [ENG-1:0][NMOD-1:0] mods_w;
  logic [ENG-1:0][31:0]     rd_w;
  logic [ENG-1:0]           busy_w;
  logic [`AITE_SEL_W-1:0]   sel_w;
  logic [4:0]               ofs_w;
  assign sel_w = addr_i[7:5];
  assign ofs_w = addr_i[4:0];

  genvar g;
  generate
    for (g = 0; g < ENG; g++) begin : gen_eng
      typedef struct packed {
        aite_pkg::aite_state_t st;
        logic [31:0] ctrl;
        logic [31:0] div;
        logic [31:0] delay;
        logic [31:0] bufsz;
        logic [31:0] pretrig;
        logic [31:0] conv;
        logic [31:0] tb_cnt;
        logic [31:0] dly_cnt;
        logic [31:0] cnt;
        logic [31:0] post;
        logic [31:0] cv_cnt;
        logic [4:0]  ch_left;
        logic        pend;
        logic        warn;
        logic        samp;
        logic        strt;
        logic        refp;
        logic        cpulse;
        logic        drop;
        logic        err;
      } st_t;
      st_t s_r, s_nxt;
      logic st_edge, rf_edge, pause_act, tick, wsel;
      logic [31:0] spacing;
      logic [NMOD-1:0] others_w;
      always_comb begin
        others_w = '0;
        for (int e = 0; e < ENG; e++) begin
          if (e != g) begin
            others_w = others_w | mods_w[e];
          end
        end
      end
      // analog source is rising edge (polarity 0)
      assign st_edge = s_r.ctrl[`AITE_C_STFALL]
        ? (src_d_r[s_r.ctrl[`AITE_C_STSRC_H:`AITE_C_STSRC_L]] &
           ~src_s_r[s_r.ctrl[`AITE_C_STSRC_H:`AITE_C_STSRC_L]])
        : (~src_d_r[s_r.ctrl[`AITE_C_STSRC_H:`AITE_C_STSRC_L]] &
           src_s_r[s_r.ctrl[`AITE_C_STSRC_H:`AITE_C_STSRC_L]]);
      assign rf_edge = s_r.ctrl[`AITE_C_RFFALL]
        ? (src_d_r[s_r.ctrl[`AITE_C_RFSRC_H:`AITE_C_RFSRC_L]] &
           ~src_s_r[s_r.ctrl[`AITE_C_RFSRC_H:`AITE_C_RFSRC_L]])
        : (~src_d_r[s_r.ctrl[`AITE_C_RFSRC_H:`AITE_C_RFSRC_L]] &
           src_s_r[s_r.ctrl[`AITE_C_RFSRC_H:`AITE_C_RFSRC_L]]);
      assign pause_act = s_r.ctrl[`AITE_C_PSEN] &
        (src_s_r[s_r.ctrl[`AITE_C_PSSRC_H:`AITE_C_PSSRC_L]] ^
         s_r.ctrl[`AITE_C_PSLOW]);
      // strobe from divided timebase or external strobe
      assign tick = s_r.ctrl[`AITE_C_EXTCLK]
        ? (ext_s_r[g] & ~ext_d_r[g])
        : (s_r.tb_cnt == 32'h00000000);
      // explicit rate wins, else pad, else spread evenly
      assign spacing = (s_r.conv != 32'h00000000) ? s_r.conv :
        ((s_r.div >= `AITE_PAD_CYC * 32'(s_r.ctrl[`AITE_C_NCH_H:
          `AITE_C_NCH_L] + 4'h1)) ? `AITE_PAD_CYC :
          s_r.div / 32'(s_r.ctrl[`AITE_C_NCH_H:`AITE_C_NCH_L] + 4'h1));
      assign wsel = wr_i && (sel_w == `AITE_SEL_W'(g));
      always_comb begin
        s_nxt = s_r;
        s_nxt.samp = 1'b0;
        s_nxt.strt = 1'b0;
        s_nxt.refp = 1'b0;
        s_nxt.cpulse = 1'b0;
        s_nxt.drop = 1'b0;
        if (wsel) begin
          unique case (ofs_w)
            `AITE_OFS_CTRL:    s_nxt.ctrl = wdata_i;
            `AITE_OFS_DIV:     s_nxt.div = wdata_i;
            `AITE_OFS_DELAY:   s_nxt.delay = wdata_i;
            `AITE_OFS_BUFSZ:   s_nxt.bufsz = wdata_i;
            `AITE_OFS_PRETRIG: s_nxt.pretrig = wdata_i;
            `AITE_OFS_CONV:    s_nxt.conv = wdata_i;
            `AITE_OFS_STATUS:  s_nxt.warn = 1'b0;
            default: ;
          endcase
        end
        // Internal timebase divider, runs only in run, prefill and post states
        if (s_r.st inside {aite_pkg::AITE_RUN, aite_pkg::AITE_PREFILL,
                           aite_pkg::AITE_POST}) begin
          s_nxt.tb_cnt = (s_r.tb_cnt == 32'h00000000) ?
            s_r.div - 32'h00000001 : s_r.tb_cnt - 32'h00000001;
        end
        if (s_r.ch_left != 5'h00) begin
          if (s_r.cv_cnt == 32'h00000000) begin
            s_nxt.cpulse = 1'b1;
            s_nxt.ch_left = s_r.ch_left - 5'h01;
            s_nxt.cv_cnt = spacing - 32'h00000001;
          end else begin
            s_nxt.cv_cnt = s_r.cv_cnt - 32'h00000001;
          end
        end
        unique case (s_r.st)
          aite_pkg::AITE_IDLE: begin
            if (wsel && ofs_w == `AITE_OFS_CTRL &&
                wdata_i[`AITE_C_RUN]) begin
              s_nxt.err = (wdata_i[`AITE_C_HARDWARE_TIMED_SINGLE_POINT] &
                           ~wdata_i[`AITE_C_TIMING]) |
                          (|(wdata_i[`AITE_C_MODS_H:`AITE_C_MODS_L] &
                             others_w));
              if (!s_nxt.err) begin
                s_nxt.st = aite_pkg::AITE_ARMED;
                s_nxt.cnt = '0;
                s_nxt.tb_cnt = '0;
                s_nxt.dly_cnt = wdata_i[`AITE_C_EXTCLK] ?
                  32'h00000000 : s_r.delay;
              end
            end
          end
          aite_pkg::AITE_ARMED: begin
            if (st_edge) begin
              s_nxt.strt = 1'b1;
              s_nxt.tb_cnt = s_r.dly_cnt;
              s_nxt.st = s_r.ctrl[`AITE_C_REFEN] ?
                aite_pkg::AITE_PREFILL : aite_pkg::AITE_RUN;
            end
          end
          aite_pkg::AITE_PAUSED: begin
            if (!pause_act) begin
              s_nxt.st = aite_pkg::AITE_RUN;
            end
          end
          aite_pkg::AITE_DONE: begin
            if (wsel && ofs_w == `AITE_OFS_CTRL &&
                !wdata_i[`AITE_C_RUN]) begin
              s_nxt.st = aite_pkg::AITE_IDLE;
            end
          end
          default: begin
            if (pause_act && !s_r.ctrl[`AITE_C_EXTCLK] &&
                s_r.st == aite_pkg::AITE_RUN) begin
              s_nxt.st = aite_pkg::AITE_PAUSED;
            end else if (tick) begin
              s_nxt.samp = 1'b1;
              s_nxt.ch_left = {1'b0, s_r.ctrl[`AITE_C_NCH_H:`AITE_C_NCH_L]} +
                              5'h01;
              s_nxt.cv_cnt = '0;
              s_nxt.cnt = s_r.cnt + 32'h00000001;
              // unread sample at next tick warns
              if (s_r.ctrl[`AITE_C_HARDWARE_TIMED_SINGLE_POINT]) begin
                s_nxt.warn = s_nxt.warn | s_r.pend;
                s_nxt.pend = 1'b1;
              end
              if (s_r.st == aite_pkg::AITE_PREFILL &&
                  s_r.cnt >= s_r.bufsz) begin
                s_nxt.drop = 1'b1;
              end
              if (s_r.st == aite_pkg::AITE_POST) begin
                s_nxt.post = s_r.post - 32'h00000001;
                if (s_r.post == 32'h00000001) begin
                  s_nxt.st = aite_pkg::AITE_DONE;
                end
              end
              if (s_r.st == aite_pkg::AITE_RUN &&
                  !s_r.ctrl[`AITE_C_CONT] && !s_r.ctrl[`AITE_C_HARDWARE_TIMED_SINGLE_POINT] &&
                  s_r.cnt + 32'h00000001 >= s_r.bufsz) begin
                s_nxt.st = aite_pkg::AITE_DONE;
              end
            end
            if (s_r.st == aite_pkg::AITE_PREFILL && rf_edge &&
                s_r.cnt >= s_r.pretrig) begin
              s_nxt.refp = 1'b1;
              s_nxt.post = s_r.bufsz - s_r.pretrig;
              s_nxt.st = (s_r.bufsz == s_r.pretrig) ?
                aite_pkg::AITE_DONE : aite_pkg::AITE_POST;
            end
          end
        endcase
        // host read clears pending, tick set wins
        if (sample_read_i[g] && !(s_nxt.samp &&
            s_r.ctrl[`AITE_C_HARDWARE_TIMED_SINGLE_POINT])) begin
          s_nxt.pend = 1'b0;
        end
        if (wsel && ofs_w == `AITE_OFS_CTRL && wdata_i[`AITE_C_STOP] &&
            s_r.st != aite_pkg::AITE_IDLE) begin
          s_nxt.st = aite_pkg::AITE_DONE;
          s_nxt.ch_left = '0;
          s_nxt.samp = 1'b0;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s_r <= '{st: aite_pkg::AITE_IDLE, ctrl: `AITE_CTRL_RST,
                   div: `AITE_DIV_RST, default: '0};
        end else begin
          s_r <= s_nxt;
        end
      end
      assign busy_w[g] = s_r.st != aite_pkg::AITE_IDLE;
      assign mods_w[g] = busy_w[g] ?
        s_r.ctrl[`AITE_C_MODS_H:`AITE_C_MODS_L] : '0;
      // sample strobe out, active high; timebase never routed
      assign route_o.sample[g] = s_r.samp;
      assign route_o.start[g] = s_r.strt;
      assign route_o.refer[g] = s_r.refp;
      assign store_o[g] = s_r.samp & ~s_r.ctrl[`AITE_C_HARDWARE_TIMED_SINGLE_POINT];
      assign drop_oldest_o[g] = s_r.drop;
      assign late_warn_o[g] = s_r.warn;
      assign conv_o.pulse[g] = s_r.cpulse;
      assign conv_o.mods[g] = s_r.cpulse & (|mods_w[g]);
      always_comb begin
        unique case (ofs_w)
          `AITE_OFS_CTRL:    rd_w[g] = s_r.ctrl;
          `AITE_OFS_DIV:     rd_w[g] = s_r.div;
          `AITE_OFS_DELAY:   rd_w[g] = s_r.delay;
          `AITE_OFS_BUFSZ:   rd_w[g] = s_r.bufsz;
          `AITE_OFS_PRETRIG: rd_w[g] = s_r.pretrig;
          `AITE_OFS_CONV:    rd_w[g] = s_r.conv;
          `AITE_OFS_STATUS:  rd_w[g] = {26'h0, s_r.err, s_r.warn,
                                        1'b0, 3'(s_r.st)};
          `AITE_OFS_COUNT:   rd_w[g] = s_r.cnt;
          default:           rd_w[g] = 32'h00000000;
        endcase
      end
      // Strobe sample marks one full channel burst
      burst_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_r.samp |-> s_r.ch_left ==
          {1'b0, s_r.ctrl[`AITE_C_NCH_H:`AITE_C_NCH_L]} + 5'h01)
        else $error("convert burst length wrong");
      ref_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_r.refp |-> $past(s_r.cnt) >= s_r.pretrig)
        else $error("reference before pretrigger");
      pause_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_r.st == aite_pkg::AITE_PAUSED |=> !s_r.samp)
        else $error("strobe while paused");
      start_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_r.strt |-> $past(s_r.st) == aite_pkg::AITE_ARMED)
        else $error("start pulse outside armed");
      post_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_r.st == aite_pkg::AITE_POST) |->
          s_r.post == s_r.bufsz - s_r.pretrig)
        else $error("posttrigger count wrong");
      warn_late_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_r.warn) |-> $past(s_r.pend) && s_r.samp)
        else $error("warning without late read");
      hardware_timed_single_point_nobuf_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_r.ctrl[`AITE_C_HARDWARE_TIMED_SINGLE_POINT] |-> !store_o[g])
        else $error("single point stored a sample");
      drop_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_r.drop |-> $past(s_r.cnt) >= s_r.bufsz)
        else $error("drop before buffer full");
      // Run requests that must be refused
      sequence run_req_s;
        wsel && ofs_w == `AITE_OFS_CTRL && wdata_i[`AITE_C_RUN] &&
        s_r.st == aite_pkg::AITE_IDLE;
      endsequence
      sequence bad_timing_s;
        wdata_i[`AITE_C_HARDWARE_TIMED_SINGLE_POINT] && !wdata_i[`AITE_C_TIMING];
      endsequence
      sequence claim_s;
        |(wdata_i[`AITE_C_MODS_H:`AITE_C_MODS_L] & others_w);
      endsequence
      sp_refuse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        run_req_s ##0 bad_timing_s |=> s_r.st == aite_pkg::AITE_IDLE && s_r.err)
        else $error("single point run not refused");
      mod_claim_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        run_req_s ##0 claim_s |=> s_r.st == aite_pkg::AITE_IDLE && s_r.err)
        else $error("claimed module run not refused");
    end
  endgenerate

  // flag modules claimed by two active engines
  always_comb begin
    logic [NMOD-1:0] seen;
    seen = '0;
    mod_conflict_o = '0;
    for (int e = 0; e < ENG; e++) begin
      mod_conflict_o = mod_conflict_o | (seen & mods_w[e]);
      seen = seen | mods_w[e];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_w[sel_w] : 32'h00000000;
    end
  end
endmodule

/* File: aite_engine_tb.sv */
// Self-checking bench for the input timing engine
`timescale 1ns/100ps
`include "aite_defines.svh"
module aite_engine_tb;
  localparam logic [31:0] RUN  = 32'h1 << `AITE_C_RUN;
  localparam logic [31:0] STOP = 32'h1 << `AITE_C_STOP;
  localparam logic [31:0] CONT = 32'h1 << `AITE_C_CONT;
  localparam logic [31:0] SP   = 32'h1 << `AITE_C_HARDWARE_TIMED_SINGLE_POINT;
  localparam logic [31:0] EXT  = 32'h1 << `AITE_C_EXTCLK;
  localparam logic [31:0] REF  = 32'h1 << `AITE_C_REFEN;
  localparam logic [31:0] PS   = 32'h1 << `AITE_C_PSEN;
  localparam logic [31:0] TIM  = 32'h1 << `AITE_C_TIMING;
  localparam logic [31:0] ST7  = 32'h7 << `AITE_C_STSRC_L;
  localparam logic [31:0] M0   = 32'h1 << `AITE_C_MODS_L;
  logic                  clk_i;
  logic                  rst_i         = 1'b1;
  logic [7:0]            addr_i        = 8'h00;
  logic [31:0]           wdata_i       = 32'h0;
  logic                  wr_i          = 1'b0;
  logic                  rd_i          = 1'b0;
  logic [7:0]            trig_src_i    = 8'h10;
  logic [7:0]            ext_strobe_i  = 8'h00;
  logic [7:0]            sample_read_i = 8'h00;
  logic                  ack_en        = 1'b1;
  logic [31:0]           rdata_o;
  aite_pkg::aite_route_t route_o;
  aite_pkg::aite_conv_t  conv_o;
  logic [7:0]            store_o;
  logic [7:0]            drop_o;
  logic [7:0]            late_warn_o;
  logic [7:0]            mod_conflict_o;
  int                    n_samp [8];
  int                    n_conv [8];
  int                    n_mods [8];
  int                    n_store [8];
  int                    n_drop [8];
  int                    n_start [8];
  int                    n_ref [8];
  int                    errors   = 0;
  int                    n_checks = 0;

  aite_engine i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .trig_src_i(trig_src_i), .ext_strobe_i(ext_strobe_i),
    .sample_read_i(sample_read_i), .route_o(route_o), .conv_o(conv_o),
    .store_o(store_o), .drop_oldest_o(drop_o), .late_warn_o(late_warn_o),
    .mod_conflict_o(mod_conflict_o));
  aite_mod_model i_mod (.clk_i(clk_i), .rst_i(rst_i), .conv_i(conv_o),
    .route_i(route_o), .store_i(store_o), .drop_i(drop_o),
    .n_samp_o(n_samp), .n_conv_o(n_conv), .n_mods_o(n_mods),
    .n_store_o(n_store), .n_drop_o(n_drop), .n_start_o(n_start),
    .n_ref_o(n_ref));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Host acknowledges each single-point sample one cycle later while ack_en is set
  always @(posedge clk_i) begin
    sample_read_i <= ack_en ? route_o.sample : 8'h00;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      errors++;
      $display("unexpected at %0t: got %0h want %0h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [2:0] e, input logic [4:0] o,
                    input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= {e, o};
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] e, input logic [4:0] o,
                    output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= {e, o};
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic waitst(input logic [2:0] e, input logic [2:0] s);
    logic [31:0] d;
    int          n;
    n = 0;
    rd(e, `AITE_OFS_STATUS, d);
    while (d[2:0] !== s && n < 2000) begin
      rd(e, `AITE_OFS_STATUS, d);
      n++;
    end
    chk(d[2:0], s);
  endtask
  task automatic tpulse(input int b);
    @(posedge clk_i);
    trig_src_i[b] <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig_src_i[b] <= 1'b0;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  initial begin
    logic [31:0] d;
    int          n;
    int          s0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(3'h0, `AITE_OFS_CTRL, d);
    chk(d, `AITE_CTRL_RST);
    rd(3'h7, `AITE_OFS_DIV, d);
    chk(d, `AITE_DIV_RST);
    wr(3'h0, 5'h02, 32'hFFFFFFFF);
    rd(3'h0, 5'h02, d);
    chk(d, 32'h0);
    @(posedge clk_i);
    #1;
    chk(rdata_o, 32'h0);
    $display("register test done");
    wr(3'h1, `AITE_OFS_CTRL, RUN | SP | CONT);
    rd(3'h1, `AITE_OFS_STATUS, d);
    chk(d & 32'h27, 32'h20);
    wr(3'h0, `AITE_OFS_CTRL, RUN | M0);
    wr(3'h1, `AITE_OFS_CTRL, RUN | M0);
    rd(3'h1, `AITE_OFS_STATUS, d);
    chk(d & 32'h27, 32'h20);
    wr(3'h1, `AITE_OFS_CTRL, RUN);
    wr(3'h1, `AITE_OFS_CTRL, RUN | M0);
    #1;
    chk(mod_conflict_o, 8'h01);
    wr(3'h1, `AITE_OFS_CTRL, 32'h0);
    #1;
    chk(mod_conflict_o, 8'h00);
    $display("refusal test done");
    wr(3'h2, `AITE_OFS_DIV, 32'hC7);
    wr(3'h2, `AITE_OFS_DELAY, 32'h32);
    wr(3'h2, `AITE_OFS_BUFSZ, 32'h3);
    wr(3'h2, `AITE_OFS_CTRL, RUN | (32'h3 << `AITE_C_STSRC_L) |
       (32'h02 << `AITE_C_MODS_L) | (32'h2 << `AITE_C_NCH_L));
    wr(3'h3, `AITE_OFS_BUFSZ, 32'h1);
    wr(3'h3, `AITE_OFS_CTRL, RUN | (32'h4 << `AITE_C_STSRC_L) |
       (32'h1 << `AITE_C_STFALL));
    waitst(3'h2, aite_pkg::AITE_ARMED);
    chk(n_start[3], 0);
    @(posedge clk_i);
    trig_src_i[3] <= 1'b1;
    trig_src_i[4] <= 1'b0;
    n = 0;
    while (route_o.start[2] !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(route_o.start[3:2], 2'b11);
    @(posedge clk_i);
    #1;
    chk(route_o.start[3:2], 2'b00);
    trig_src_i[3] <= 1'b0;
    n = 0;
    while (route_o.sample[2] !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(n >= 48, 1);
    waitst(3'h2, aite_pkg::AITE_DONE);
    repeat (250) @(posedge clk_i);
    chk(n_samp[2], 3);
    chk(n_store[2], 3);
    chk(n_conv[2], 9);
    chk(n_mods[2], 9);
    $display("start test done");
    wr(3'h4, `AITE_OFS_DIV, 32'h31);
    wr(3'h4, `AITE_OFS_BUFSZ, 32'h6);
    wr(3'h4, `AITE_OFS_PRETRIG, 32'h3);
    wr(3'h4, `AITE_OFS_CTRL, RUN | REF | ST7 | (32'h5 << `AITE_C_RFSRC_L));
    wr(3'h5, `AITE_OFS_DIV, 32'h31);
    wr(3'h5, `AITE_OFS_CTRL, RUN | CONT | PS | ST7 |
       (32'h6 << `AITE_C_PSSRC_L));
    wr(3'h6, `AITE_OFS_DIV, 32'h63);
    wr(3'h6, `AITE_OFS_CTRL, RUN | CONT | SP | TIM | ST7);
    wr(3'h7, `AITE_OFS_CTRL, RUN | CONT | EXT | ST7);
    tpulse(7);
    tpulse(5);
    repeat (10) @(posedge clk_i);
    chk(n_ref[4], 0);
    repeat (600) @(posedge clk_i);
    chk(n_drop[4] > 0, 1);
    @(posedge clk_i);
    trig_src_i[5] <= 1'b1;
    n = 0;
    while (route_o.refer[4] !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    @(posedge clk_i);
    #1;
    s0 = n_store[4];
    trig_src_i[5] <= 1'b0;
    waitst(3'h4, aite_pkg::AITE_DONE);
    chk(n_ref[4], 1);
    chk(n_store[4] - s0, 3);
    $display("reference test done");
    chk(n_samp[5] > 0, 1);
    @(posedge clk_i);
    trig_src_i[6] <= 1'b1;
    repeat (10) @(posedge clk_i);
    s0 = n_samp[5];
    repeat (300) @(posedge clk_i);
    chk(n_samp[5], s0);
    waitst(3'h5, aite_pkg::AITE_PAUSED);
    trig_src_i[6] <= 1'b0;
    repeat (200) @(posedge clk_i);
    chk(n_samp[5] > s0, 1);
    wr(3'h5, `AITE_OFS_CTRL, STOP);
    rd(3'h5, `AITE_OFS_STATUS, d);
    chk(d[2:0], aite_pkg::AITE_DONE);
    $display("pause test done");
    chk(late_warn_o[6], 1'b0);
    chk(n_store[6], 0);
    chk(n_samp[6] > 0, 1);
    ack_en <= 1'b0;
    repeat (300) @(posedge clk_i);
    #1;
    chk(late_warn_o[6], 1'b1);
    rd(3'h6, `AITE_OFS_STATUS, d);
    chk(d[4], 1'b1);
    ack_en <= 1'b1;
    repeat (250) @(posedge clk_i);
    wr(3'h6, `AITE_OFS_STATUS, 32'h0);
    repeat (150) @(posedge clk_i);
    #1;
    chk(late_warn_o[6], 1'b0);
    $display("single point test done");
    chk(n_samp[7], 0);
    repeat (4) begin
      @(posedge clk_i);
      ext_strobe_i[7] <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_strobe_i[7] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    chk(n_samp[7], 4);
    $display("external clock test done");
    end_sim();
  end
endmodule

/* File: aite_mod_model.sv */
// Behavioural model of the converter modules and sample sink
`timescale 1ns/100ps
module aite_mod_model (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire aite_pkg::aite_conv_t  conv_i,
  input  wire aite_pkg::aite_route_t route_i,
  input  wire logic [7:0]            store_i,
  input  wire logic [7:0]            drop_i,
  output int                         n_samp_o  [8],
  output int                         n_conv_o  [8],
  output int                         n_mods_o  [8],
  output int                         n_store_o [8],
  output int                         n_drop_o  [8],
  output int                         n_start_o [8],
  output int                         n_ref_o   [8]
);
  always @(posedge clk_i) begin
    for (int e = 0; e < 8; e++) begin
      if (rst_i) begin
        n_samp_o[e]  <= 0;
        n_conv_o[e]  <= 0;
        n_mods_o[e]  <= 0;
        n_store_o[e] <= 0;
        n_drop_o[e]  <= 0;
        n_start_o[e] <= 0;
        n_ref_o[e]   <= 0;
      end else begin
        n_samp_o[e]  <= n_samp_o[e] + int'(route_i.sample[e]);
        n_conv_o[e]  <= n_conv_o[e] + int'(conv_i.pulse[e]);
        n_mods_o[e]  <= n_mods_o[e] + int'(conv_i.mods[e]);
        // buffer traffic seen by the sink
        n_store_o[e] <= n_store_o[e] + int'(store_i[e]);
        n_drop_o[e]  <= n_drop_o[e] + int'(drop_i[e]);
        n_start_o[e] <= n_start_o[e] + int'(route_i.start[e]);
        n_ref_o[e]   <= n_ref_o[e] + int'(route_i.refer[e]);
      end
    end
  end
endmodule

/* File: aite_pkg.sv */
// Types shared by the input timing engine
package aite_pkg;
  typedef enum logic [2:0] {
    AITE_IDLE, AITE_ARMED, AITE_RUN, AITE_PAUSED,
    AITE_PREFILL, AITE_POST, AITE_DONE
  } aite_state_t;
  typedef struct packed {
    logic [7:0] pulse;
    logic [7:0] mods;
  } aite_conv_t;
  typedef struct packed {
    logic [7:0] sample;
    logic [7:0] start;
    logic [7:0] refer;
  } aite_route_t;
endpackage
